// *** hw/apc_ctrl.sv ***
// Converter control with power-fail threshold compare, reached over APB.
// Assumes a front end that delivers the digitised sample of the selected channel.
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "apc_consts.svh"

module apc_ctrl #(
  parameter int CONV_CYCLES = `APC_CONV_CYC
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // APB slave
  input  wire apc_pkg::apc_apb_req_t apb_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Converter front end
  input  wire logic [7:0]           sample_i,
  input  wire logic                 standby_i,
  output logic [`APC_CHAN_W-1:0]    chan_sel_o,
  output logic                      conv_busy_o,
  // Events and reference enable
  output logic                      conv_end_irq_o,
  output logic                      conv_end_flag_o,
  output logic                      ref_voltage_en_o
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

  apc_pkg::apc_state_t state_reg, state_next;
  logic [CW-1:0]  cnt_reg, cnt_next;
  logic           start_reg, start_next;
  logic           cmpen_reg, cmpen_next;
  logic           pol_reg, pol_next;
  logic [7:0]     thresh_reg, thresh_next;
  logic [`APC_CHAN_W-1:0] chan_reg, chan_next;
  logic [7:0]     result_reg, result_next;
  logic           flag_reg, flag_next;
  logic           irq_reg, irq_next;
  logic           first_reg, first_next;
  logic           ref_reg, ref_next;
  logic [31:0]    prdata_reg, prdata_next;
  logic           pready_reg, pready_next;
  logic           pslverr_reg, pslverr_next;
  logic [7:0]     s1_reg, s2_reg, s3_reg, smp_reg, smp_next;

  logic [15:0] idx;
  logic        hit, wr, ctl_wr, done, run, cmp_ok, mapped;

  assign idx    = apb_i.paddr[17:2];
  assign wr     = apb_i.psel & apb_i.penable & pready_reg & apb_i.pwrite;
  assign ctl_wr = wr & ((idx == `APC_IDX_CONVMODE) | (idx == `APC_IDX_CHAN));
  assign run    = start_reg & ~standby_i;
  assign done   = (state_reg == apc_pkg::APC_CONV) & run & (cnt_reg == LAST);
  assign cmp_ok = pol_reg ? (smp_reg < thresh_reg) : (smp_reg >= thresh_reg);
  assign mapped = (idx >= `APC_IDX_FLAG) & (idx <= `APC_IDX_REFCTRL);

  // The sample bus changes outside this clock; a value counts once the
  // last two stages agree, so a half-settled code is never taken.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg  <= `APC_RST_BYTE;
      s2_reg  <= `APC_RST_BYTE;
      s3_reg  <= `APC_RST_BYTE;
      smp_reg <= `APC_RST_BYTE;
    end else begin
      s1_reg  <= sample_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      smp_reg <= smp_next;
    end
  end

  always_comb begin
    smp_next = (s2_reg == s3_reg) ? s3_reg : smp_reg;
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    result_next = result_reg;
    flag_next  = flag_reg;
    irq_next   = 1'b0;
    first_next = first_reg;
    hit        = 1'b0;
    if (!start_reg) begin
      state_next = apc_pkg::APC_IDLE;
      cnt_next   = '0;
    end else if (!standby_i) begin
      state_next = apc_pkg::APC_CONV;
      cnt_next   = (state_reg == apc_pkg::APC_CONV && cnt_reg != LAST) ? cnt_reg + 1'b1 : '0;
    end
    if (done && !ctl_wr) begin
      result_next = smp_reg;
      first_next  = 1'b0;
      hit = cmpen_reg ? (cmp_ok & ~first_reg) : 1'b1;
    end
    if (ctl_wr) begin
      cnt_next = '0;
      state_next = apc_pkg::APC_IDLE;
    end
    if (wr && idx == `APC_IDX_CONVMODE && apb_i.pwdata[`APC_BIT_START] && !start_reg) begin
      first_next = 1'b1;
    end
    if (wr && idx == `APC_IDX_FLAG && !apb_i.pwdata[`APC_BIT_FLAG]) begin
      flag_next = 1'b0;
    end
    if (hit) begin
      flag_next = 1'b1;
      irq_next  = 1'b1;
    end
  end

  always_comb begin
    start_next  = start_reg;
    cmpen_next  = cmpen_reg;
    pol_next    = pol_reg;
    thresh_next = thresh_reg;
    chan_next   = chan_reg;
    ref_next    = ref_reg;
    if (wr) begin
      case (idx)
        `APC_IDX_CONVMODE: start_next = apb_i.pwdata[`APC_BIT_START];
        `APC_IDX_CMPMODE: begin
          cmpen_next = apb_i.pwdata[`APC_BIT_CMPEN];
          pol_next   = apb_i.pwdata[`APC_BIT_CMPPOL];
        end
        `APC_IDX_THRESH: thresh_next = apb_i.pwdata[7:0];
        `APC_IDX_CHAN: begin
          if (apb_i.pwdata[`APC_CHAN_W-1:0] <= `APC_CHAN_MAX) begin
            chan_next = apb_i.pwdata[`APC_CHAN_W-1:0];
          end
        end
        `APC_IDX_REFCTRL: ref_next = apb_i.pwdata[`APC_BIT_REFEN];
        default: ;
      endcase
    end
  end

  // Read data is captured on the first access cycle, before any result
  // landing on the same edge, so a colliding read sees the old value.
  always_comb begin
    prdata_next  = 32'h0;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (apb_i.psel && apb_i.penable && !pready_reg) begin
      pready_next  = 1'b1;
      pslverr_next = ~mapped;
      if (!apb_i.pwrite) begin
        case (idx)
          `APC_IDX_CONVMODE: prdata_next[`APC_BIT_START] = start_reg;
          `APC_IDX_CMPMODE:  prdata_next[7:6] = {cmpen_reg, pol_reg};
          `APC_IDX_THRESH:   prdata_next[7:0] = thresh_reg;
          `APC_IDX_CHAN:     prdata_next[`APC_CHAN_W-1:0] = chan_reg;
          `APC_IDX_RESULT:   prdata_next[7:0] = result_reg;
          `APC_IDX_FLAG:     prdata_next[`APC_BIT_FLAG] = flag_reg;
          default:           prdata_next = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg   <= apc_pkg::APC_IDLE;
      cnt_reg     <= '0;
      start_reg   <= 1'b0;
      cmpen_reg   <= 1'b0;
      pol_reg     <= 1'b0;
      thresh_reg  <= `APC_RST_BYTE;
      chan_reg    <= `APC_RST_CHAN;
      result_reg  <= `APC_RST_BYTE;
      flag_reg    <= 1'b0;
      irq_reg     <= 1'b0;
      first_reg   <= 1'b0;
      ref_reg     <= 1'b0;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      start_reg   <= start_next;
      cmpen_reg   <= cmpen_next;
      pol_reg     <= pol_next;
      thresh_reg  <= thresh_next;
      chan_reg    <= chan_next;
      result_reg  <= result_next;
      flag_reg    <= flag_next;
      irq_reg     <= irq_next;
      first_reg   <= first_next;
      ref_reg     <= ref_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_o         = prdata_reg;
  assign pready_o         = pready_reg;
  assign pslverr_o        = pslverr_reg;
  assign chan_sel_o       = chan_reg;
  assign conv_busy_o      = (state_reg == apc_pkg::APC_CONV);
  assign conv_end_irq_o   = irq_reg;
  assign conv_end_flag_o  = flag_reg;
  assign ref_voltage_en_o = ref_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  irq_needs_done_a: assert property (irq_next |-> done && !ctl_wr)
    else $error("Interrupt without a clean completion.");
  cmp_polarity_a: assert property (done && !ctl_wr && cmpen_reg && !first_reg |=>
      conv_end_irq_o == $past(cmp_ok))
    else $error("Compare interrupt disagrees with polarity.");
  first_silent_a: assert property (done && cmpen_reg && first_reg |=> !conv_end_irq_o)
    else $error("First compare completion raised an interrupt.");
  stop_idle_a: assert property (!start_reg |=> !conv_busy_o)
    else $error("Converter busy with start bit clear.");
  standby_hold_a: assert property (standby_i && conv_busy_o && start_reg && !ctl_wr |=>
      $stable(cnt_reg))
    else $error("Counter moved in standby.");
  ctl_drop_a: assert property (done && ctl_wr |=> $stable(result_reg) && !conv_end_irq_o)
    else $error("Result stored despite control write.");
  flag_keep_a: assert property (flag_reg && !(wr && idx == `APC_IDX_FLAG) |=> flag_reg)
    else $error("End flag cleared by hardware.");
  restart_a: assert property (ctl_wr |=> cnt_reg == '0)
    else $error("Control write did not restart conversion.");
  chan_range_a: assert property (chan_sel_o <= `APC_CHAN_MAX)
    else $error("Prohibited channel selected.");
  thr_write_a: assert property (wr && idx == `APC_IDX_THRESH |=>
      thresh_reg == $past(apb_i.pwdata[7:0]))
    else $error("Threshold write lost.");

  // Every check below samples on the rising clock and is muted while reset is low.
  result_hold_a: assert property (!(done && !ctl_wr) |=> $stable(result_reg))
    else $error("Result changed without a clean completion.");
  start_busy_a: assert property (start_reg && !standby_i && !ctl_wr |=> conv_busy_o)
    else $error("Converter idle with start bit set.");
  read_old_a: assert property (apb_i.psel && apb_i.penable && !pready_reg &&
      !apb_i.pwrite && idx == `APC_IDX_RESULT |=> prdata_o[7:0] == $past(result_reg))
    else $error("Result read did not return the old value.");
  ref_noread_a: assert property (apb_i.psel && apb_i.penable && !pready_reg &&
      !apb_i.pwrite && idx == `APC_IDX_REFCTRL |=> prdata_o == 32'h0)
    else $error("Write-only reference register read back nonzero.");
  first_arm_a: assert property (wr && idx == `APC_IDX_CONVMODE &&
      apb_i.pwdata[`APC_BIT_START] && !start_reg |=> first_reg)
    else $error("Start did not arm first-completion silence.");
  normal_irq_a: assert property (done && !ctl_wr && !cmpen_reg |=> conv_end_irq_o)
    else $error("Normal-mode completion raised no interrupt.");
  standby_irq_a: assert property (standby_i |=> !conv_end_irq_o)
    else $error("Interrupt raised in standby.");
  irq_flag_a: assert property (conv_end_irq_o |-> conv_end_flag_o)
    else $error("Interrupt without end flag.");
  // A clear and a completion on one edge leave the flag set, hence the exclusion.
  flag_clear_a: assert property (wr && idx == `APC_IDX_FLAG &&
      !apb_i.pwdata[`APC_BIT_FLAG] && !hit |=> !conv_end_flag_o)
    else $error("Software clear of end flag lost.");
  ref_write_a: assert property (wr && idx == `APC_IDX_REFCTRL |=>
      ref_voltage_en_o == $past(apb_i.pwdata[`APC_BIT_REFEN]))
    else $error("Reference enable write lost.");
  chan_keep_a: assert property (wr && idx == `APC_IDX_CHAN &&
      apb_i.pwdata[`APC_CHAN_W-1:0] > `APC_CHAN_MAX |=> $stable(chan_reg))
    else $error("Prohibited channel code accepted.");

endmodule
`default_nettype wire

// *** hw/apc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the compare controller.
// Assumes inclusion by bare name from the design and bench files.
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// Register indices; the APB byte address is four times the index.
`define APC_IDX_CHAN      16'hff99
`define APC_IDX_CMPMODE   16'hff9a
`define APC_IDX_THRESH    16'hff9b
`define APC_IDX_REFCTRL   16'hff9c
`define APC_IDX_CONVMODE  16'hff98
`define APC_IDX_RESULT    16'hff97
`define APC_IDX_FLAG      16'hff96

// Field positions and the channel field width.
`define APC_BIT_START     7
`define APC_BIT_CMPEN     7
`define APC_BIT_CMPPOL    6
`define APC_BIT_REFEN     0
`define APC_BIT_FLAG      0
`define APC_CHAN_W        3

// Reset values and the highest permitted channel code.
`define APC_RST_BYTE      8'h00
`define APC_RST_CHAN      3'h0
`define APC_CHAN_MAX      3'h4

// Timing: least conversion time, rounded up to whole clock cycles.
`define APC_CLK_PERIOD_NS 10
`define APC_CONV_TIME_NS  14000
`define APC_CONV_CYC      ((`APC_CONV_TIME_NS + `APC_CLK_PERIOD_NS - 1) / `APC_CLK_PERIOD_NS)

`endif

// *** hw/apc_pkg.sv ***
// Types shared by the compare controller and its bench.
// Assumes apc_consts.svh is compiled alongside.
package apc_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apc_apb_req_t;

  typedef enum logic {
    APC_IDLE,
    APC_CONV
  } apc_state_t;

endpackage

// *** bench/apc_analog_src.sv ***
// Model of the five analog sources behind the converter front end.
// Assumes the bench sets one level for each channel and holds it steady.
`timescale 1ns/10ps
`default_nettype none
module apc_analog_src (
  // Channel levels and selection
  input  wire logic [4:0][7:0] levels_i,
  input  wire logic [2:0]      chan_sel_i,
  // Digitised sample
  output logic [7:0]           sample_o
);
  // codes above four
  // A prohibited code selects no pin; a fixed odd pattern stands in for it.
  // no port reads
  // The bench never reads the shared pins as a port while a conversion runs.
  assign sample_o = (chan_sel_i <= 3'h4) ? levels_i[chan_sel_i] : 8'ha5;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the compare controller, APB master and reference model.
// Assumes the design files and the analog source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "apc_consts.svh"
module tb_top;
  logic                  clk_i, resetn_i, standby_i, er;
  apc_pkg::apc_apb_req_t apb;
  logic [31:0]           prdata_o, rd, seed;
  logic                  pready_o, pslverr_o, busy, irq, flag, refen;
  logic [2:0]            chan;
  logic [7:0]            sample, thr;
  logic [4:0][7:0]       levels;
  int                    errors, checks, cnt, ex;
  apc_ctrl #(.CONV_CYCLES(8)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample),
    .standby_i(standby_i), .chan_sel_o(chan), .conv_busy_o(busy), .conv_end_irq_o(irq),
    .conv_end_flag_o(flag), .ref_voltage_en_o(refen));
  apc_analog_src src (.levels_i(levels), .chan_sel_i(chan), .sample_o(sample));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The request is held until pready is seen at an edge; data is taken there.
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    apb <= '{1'b1, 1'b0, w, {14'h0, idx, 2'b00}, {24'h0, d}};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    apb <= '0;
  endtask
  task automatic cnt_irq(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (irq === 1'b1) cnt++;
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up;
  end
  initial begin
    resetn_i = 1'b0;
    standby_i = 1'b0;
    apb = '0;
    levels = '0;
    seed = 32'hb7a88fd8;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(0, `APC_IDX_THRESH, 0); chk(rd, 0);
    bus(0, `APC_IDX_CMPMODE, 0); chk(rd, 0);
    bus(0, 16'h0001, 0); chk({31'h0, er}, 1);
    // reference enable written with upper bits zero
    bus(1, `APC_IDX_REFCTRL, 8'h01);
    @(posedge clk_i);
    chk({31'h0, refen}, 1);
    bus(0, `APC_IDX_REFCTRL, 0); chk(rd, 0);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      levels[i % 5] <= seed[7:0];
      thr = (i == 2) ? seed[7:0] : seed[15:8];
      bus(1, `APC_IDX_CONVMODE, 8'h00);
      bus(1, `APC_IDX_FLAG, 8'h00);
      bus(1, `APC_IDX_THRESH, thr);
      bus(0, `APC_IDX_THRESH, 0); chk(rd, {24'h0, thr});
      bus(1, `APC_IDX_CMPMODE, {1'b1, i[0], 6'h0});
      bus(1, `APC_IDX_CHAN, 8'(i % 5));
      bus(1, `APC_IDX_CONVMODE, 8'h80);
      // Unsigned compare of the held level against the threshold.
      ex = i[0] ? int'(seed[7:0] < thr) : int'(seed[7:0] >= thr);
      cnt_irq(20); chk(cnt, ex);
      bus(0, `APC_IDX_RESULT, 0); chk(rd, {24'h0, seed[7:0]});
    end
    bus(1, `APC_IDX_CONVMODE, 8'h00);
    bus(1, `APC_IDX_FLAG, 8'h00);
    bus(1, `APC_IDX_CMPMODE, 8'h00);
    bus(1, `APC_IDX_CONVMODE, 8'h80);
    // The channel write is timed to land on the edge of the first completion.
    repeat (5) @(posedge clk_i);
    bus(1, `APC_IDX_CHAN, 8'h00);
    cnt_irq(8); chk(cnt, 0);
    // Standby arrives mid-conversion; one edge passes before counting.
    standby_i <= 1'b1;
    @(posedge clk_i);
    cnt_irq(30); chk(cnt, 0);
    standby_i <= 1'b0;
    cnt_irq(20); chk({31'h0, cnt != 0}, 1);
    bus(1, `APC_IDX_CHAN, 8'h03);
    bus(0, `APC_IDX_FLAG, 0); chk(rd[0], 1);
    chk({31'h0, flag}, 1);
    bus(1, `APC_IDX_CHAN, 8'h05);
    bus(0, `APC_IDX_CHAN, 0); chk(rd, 3);
    chk({29'h0, chan}, 3);
    bus(1, `APC_IDX_CONVMODE, 8'h00);
    cnt_irq(20); chk(cnt, 0);
    chk({31'h0, busy}, 0);
    // A second reset, after conversion is stopped, must clear the threshold again.
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(0, `APC_IDX_THRESH, 0); chk(rd, 0);
    wrap_up;
  end
endmodule
`default_nettype wire
